// [verilog/astr_pkg.sv]
`default_nettype none
// ==========================================================
// shared constants for the serial block
package astr_pkg;

  // character length select values
  localparam logic       LEN_8       = 1'b0;
  localparam logic       LEN_9       = 1'b1;
  // samples per bit on the receive side
  localparam int         OVERSAMPLE  = 16;
  // default baud divider, sys_clk cycles per sample tick
  localparam int         BAUD_DIV    = 13;
  // receive sample points inside a bit (ticks from bit start)
  localparam logic [3:0] SAMPLE_A    = 4'h7;
  localparam logic [3:0] SAMPLE_B    = 4'h8;
  localparam logic [3:0] SAMPLE_C    = 4'h9;
  // start bit verification points
  localparam logic [3:0] START_A     = 4'h2;
  localparam logic [3:0] START_B     = 4'h4;
  localparam logic [3:0] START_C     = 4'h6;
  // ones needed in front of a start bit
  localparam int         IDLE_ONES   = 3;
  // reset values
  localparam logic [7:0] DATA_RST    = 8'h00;

endpackage : astr_pkg
`default_nettype wire

// [verilog/astr_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sample tick and link settings shared by transmitter and top
interface astr_tick_if;
  logic tick;      // one pulse per sample period (16 per bit)
  logic len9;      // 9-bit characters
  logic enable;    // module enabled

  modport gen  (output tick, output len9, output enable);
  modport user (input tick, input len9, input enable);
endinterface : astr_tick_if
`default_nettype wire

// [verilog/astr_tx.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// transmitter: preamble, data, break and idle characters
module astr_tx (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   reset,
  // shared tick and settings
  astr_tick_if.user   tk,
  // control
  input  wire logic   tx_enable,
  input  wire logic   send_break,
  input  wire logic   tx_polarity_invert,
  input  wire logic   tx_ninth_bit,
  // buffer handshake
  input  wire logic   buf_full,
  input  wire logic [7:0] buf_data,
  output logic        buf_take,
  // line and state
  output logic        line_nxt,
  output logic        busy
);

  logic [10:0] shift_r;
  logic [3:0]  bits_r;
  logic [3:0]  sub_r;
  logic        active_r;
  logic        need_pre_r;
  logic        brk_r;
  logic        te_q_r;
  logic        idle_q_r;
  logic        te_off_r;

  // frame length in bits for data (start+data+stop) and for idle/break
  logic [3:0] dlen;
  logic [3:0] slen;
  assign dlen = tk.len9 ? 4'hb : 4'ha;
  assign slen = tk.len9 ? 4'ha : 4'h9;

  // current line level; idle high when nothing shifting
  logic lvl;
  assign lvl = active_r ? shift_r[0] : 1'b1;
  assign line_nxt = lvl ^ tx_polarity_invert;
  assign busy = active_r | buf_full | brk_r;

  logic bit_end;
  assign bit_end = tk.tick && (sub_r == 4'hf);

  // take the buffer only when data frame is being loaded
  logic load_ok;
  assign load_ok = !active_r && tk.enable && tx_enable && buf_full
                   && !need_pre_r && !send_break && !brk_r && !idle_q_r;
  assign buf_take = load_ok;

  // toggle detector for tx_enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      te_q_r <= 1'b0;
    end else begin
      te_q_r <= tx_enable;
    end
  end

  // queued idle after a clear/set of tx_enable during a frame
  always_ff @(posedge sys_clk) begin
    if (reset || !tk.enable) begin
      te_off_r <= 1'b0;
      idle_q_r <= 1'b0;
    end else begin
      if (active_r && te_q_r && !tx_enable) begin
        te_off_r <= 1'b1;
      end
      if (te_off_r && tx_enable && !te_q_r) begin
        idle_q_r <= 1'b1;
        te_off_r <= 1'b0;
      end else if (!active_r && !tx_enable) begin
        te_off_r <= 1'b0;
      end
      if (!active_r && idle_q_r && tx_enable) begin
        idle_q_r <= 1'b0;
      end
    end
  end

  // shifter: runs apart from receiver on the shared tick
  always_ff @(posedge sys_clk) begin
    if (reset || !tk.enable) begin
      shift_r    <= 11'h7ff;
      bits_r     <= 4'h0;
      sub_r      <= 4'h0;
      active_r   <= 1'b0;
      need_pre_r <= 1'b1;
      brk_r      <= 1'b0;
    end else if (active_r) begin
      if (tk.tick) begin
        sub_r <= sub_r + 4'h1;
      end
      if (bit_end) begin
        shift_r <= {1'b1, shift_r[10:1]};
        bits_r  <= bits_r - 4'h1;
        if (bits_r == 4'h1) begin
          active_r <= 1'b0;
        end
      end
    end else if (!tx_enable) begin
      // idle; next enable starts with a preamble
      need_pre_r <= 1'b1;
      brk_r      <= 1'b0;
    end else if (send_break) begin
      shift_r  <= 11'h000;
      bits_r   <= slen;
      sub_r    <= 4'h0;
      active_r <= 1'b1;
      brk_r    <= 1'b1;
    end else if (brk_r || need_pre_r || idle_q_r) begin
      shift_r    <= 11'h7ff;
      bits_r     <= brk_r ? 4'h1 : slen;
      sub_r      <= 4'h0;
      active_r   <= 1'b1;
      need_pre_r <= 1'b0;
      brk_r      <= 1'b0;
    end else if (load_ok) begin
      // start at lsb, stop at msb
      if (tk.len9) begin
        shift_r <= {1'b1, tx_ninth_bit, buf_data, 1'b0};
      end else begin
        shift_r <= {2'b11, buf_data, 1'b0};
      end
      bits_r   <= dlen;
      sub_r    <= 4'h0;
      active_r <= 1'b1;
    end
  end

endmodule : astr_tx
`default_nettype wire

// [verilog/astr_rx.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// receiver: start search, majority sampling, break detect
module astr_rx (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   reset,
  // shared tick and settings
  astr_tick_if.user   tk,
  // line
  input  wire logic   serial_in,
  // result pulse and fields
  output logic        done,
  output logic [8:0]  data,
  output logic        stop_bad,
  output logic        noisy,
  output logic        brk,
  output logic        busy
);

  typedef enum logic [1:0] {S_HUNT, S_START, S_BITS} astr_rx_state_t;
  astr_rx_state_t st_r;
  logic [2:0] ones_r;
  logic [3:0] sub_r;
  logic [3:0] idx_r;
  logic [9:0] sh_r;
  logic [2:0] smp_r;
  logic       nz_r;

  logic maj;
  assign maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2])
             | (smp_r[1] & smp_r[2]);
  logic [3:0] last;
  assign last = tk.len9 ? 4'ha : 4'h9;
  assign busy = (st_r != S_HUNT);

  // sampling at sixteen ticks a bit
  always_ff @(posedge sys_clk) begin
    if (reset || !tk.enable) begin
      st_r <= S_HUNT;
      ones_r <= 3'h0;
      sub_r <= 4'h0;
      idx_r <= 4'h0;
      sh_r <= 10'h000;
      smp_r <= 3'h0;
      nz_r <= 1'b0;
      done <= 1'b0;
      data <= 9'h000;
      stop_bad <= 1'b0;
      noisy <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tk.tick) begin
        case (st_r)
          S_HUNT: begin
            if (serial_in) begin
              ones_r <= (ones_r == 3'(astr_pkg::IDLE_ONES)) ?
                        ones_r : ones_r + 3'h1;
            end else if (ones_r == 3'(astr_pkg::IDLE_ONES)) begin
              st_r <= S_START;
              sub_r <= 4'h1;
              nz_r <= 1'b0;
            end else begin
              ones_r <= 3'h0;
            end
          end
          S_START: begin
            sub_r <= sub_r + 4'h1;
            if (sub_r == astr_pkg::START_A) smp_r[0] <= serial_in;
            if (sub_r == astr_pkg::START_B) smp_r[1] <= serial_in;
            if (sub_r == astr_pkg::START_C) begin
              if (maj | (smp_r[0] & serial_in) | (smp_r[1] & serial_in))
              begin
                st_r <= S_HUNT;
                ones_r <= 3'h0;
              end else begin
                nz_r <= smp_r[0] | smp_r[1] | serial_in;
              end
            end
            if (sub_r == 4'hf) begin
              st_r <= S_BITS;
              idx_r <= 4'h0;
            end
          end
          S_BITS: begin
            sub_r <= sub_r + 4'h1;
            if (sub_r == astr_pkg::SAMPLE_A) smp_r[0] <= serial_in;
            if (sub_r == astr_pkg::SAMPLE_B) smp_r[1] <= serial_in;
            if (sub_r == astr_pkg::SAMPLE_C) smp_r[2] <= serial_in;
            if (sub_r == 4'hb) begin
              sh_r <= {maj, sh_r[9:1]};
              if (smp_r != 3'h0 && smp_r != 3'h7) nz_r <= 1'b1;
            end
            if (sub_r == 4'hf) begin
              idx_r <= idx_r + 4'h1;
              if (idx_r + 4'h1 == last) begin
                st_r <= S_HUNT;
                ones_r <= 3'h0;
                done <= 1'b1;
                noisy <= nz_r;
                // stop bit is sh_r[9]; data below it
                stop_bad <= ~sh_r[9];
                brk <= (tk.len9 ? (sh_r == 10'h000)
                                : (sh_r[9:1] == 9'h000));
                // ninth bit or copy of bit 7
                data <= tk.len9 ? sh_r[8:0]
                                : {sh_r[8], sh_r[8:1]};
              end
            end
          end
          default: st_r <= S_HUNT;
        endcase
      end
    end
  end

endmodule : astr_rx
`default_nettype wire

// [verilog/astr_top.sv]
`timescale 1ns/1ps
`default_nettype none
module astr_top #(
  parameter int BAUD_DIV = astr_pkg::BAUD_DIV
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // control bits
  input  wire logic       module_enable,
  input  wire logic       tx_enable,
  input  wire logic       rx_enable,
  input  wire logic       char_len_sel,
  input  wire logic       send_break,
  input  wire logic       tx_polarity_invert,
  input  wire logic       tx_ninth_bit,
  input  wire logic       tx_empty_irq_en,
  input  wire logic       tx_done_irq_en,
  input  wire logic       rx_full_irq_en,
  // cpu data access
  input  wire logic       status_read,
  input  wire logic       data_write,
  input  wire logic [7:0] data_wdata,
  input  wire logic       data_read,
  // status
  output logic [7:0]      data_buffer,
  output logic            rx_ninth_bit,
  output logic            tx_buffer_empty,
  output logic            tx_complete,
  output logic            rx_buffer_full,
  output logic            framing_error,
  output logic            break_flag,
  output logic            overrun_flag,
  output logic            noise_flag,
  output logic            parity_error,
  output logic            rx_in_progress,
  output logic            tx_irq,
  output logic            rx_irq,
  // serial pins
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe
);

  // ==========================================================
  // parameter check
  if (BAUD_DIV < 1 || BAUD_DIV > 65535) begin : g_bad_div
    $error("BAUD_DIV out of range");
  end

  // ==========================================================
  // shared baud generator
  astr_tick_if tk ();
  logic [15:0] div_r;
  logic        tick_r;

  // one divider on sys_clk feeds both directions
  always_ff @(posedge sys_clk) begin
    if (reset || !module_enable) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == 16'(BAUD_DIV - 1)) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  assign tk.tick   = tick_r;
  assign tk.len9   = (char_len_sel == astr_pkg::LEN_9);
  assign tk.enable = module_enable;

  // ==========================================================
  // transmit buffer
  logic [7:0] tbuf_r;
  logic       tfull_r;
  logic       take;
  logic       line_nxt;
  logic       tx_busy;
  logic       armed_r;

  astr_tx u_tx (
    .sys_clk            (sys_clk),
    .reset              (reset),
    .tk                 (tk),
    .tx_enable          (tx_enable),
    .send_break         (send_break),
    .tx_polarity_invert (tx_polarity_invert),
    .tx_ninth_bit       (tx_ninth_bit),
    .buf_full           (tfull_r),
    .buf_data           (tbuf_r),
    .buf_take           (take),
    .line_nxt           (line_nxt),
    .busy               (tx_busy)
  );

  // a status read outside a data write cycle arms the write that clears empty, whether or not empty is set
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else if (data_write) begin
      armed_r <= 1'b0;
    end else if (status_read) begin
      armed_r <= 1'b1;
    end
  end

  // empty sets on handoff; an armed write (clear) wins over the handoff (set)
  always_ff @(posedge sys_clk) begin
    if (reset || !module_enable) begin
      tbuf_r  <= astr_pkg::DATA_RST;
      tfull_r <= 1'b0;
    end else if (data_write && armed_r) begin
      // a write in the handoff cycle refills the buffer, not lost
      tbuf_r  <= data_wdata;
      tfull_r <= 1'b1;
    end else if (take) begin
      tfull_r <= 1'b0;
    end
  end

  // ==========================================================
  // serial pins
  // release pins when disabled
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serial_out    <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out    <= module_enable ? line_nxt : 1'b1;
      // keep driving until the character in flight is done and the buffer is empty
      serial_out_oe <= module_enable & (tx_enable | tx_busy);
    end
  end

  // ==========================================================
  // transmitter status and interrupt
  // complete when nothing pending or shifting
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_buffer_empty <= 1'b1;
      tx_complete     <= 1'b1;
      tx_irq          <= 1'b0;
    end else begin
      tx_buffer_empty <= ~tfull_r | take;
      tx_complete     <= ~tfull_r & ~tx_busy;
      tx_irq <= (tx_empty_irq_en & ~tfull_r)
              | (tx_done_irq_en & ~tfull_r & ~tx_busy);
    end
  end

  // ==========================================================
  // receiver
  astr_tick_if rtk ();
  logic       r_done;
  logic [8:0] r_data;
  logic       r_stop_bad;
  logic       r_noisy;
  logic       r_brk;
  logic       r_busy;

  assign rtk.tick   = tick_r;
  assign rtk.len9   = tk.len9;
  assign rtk.enable = module_enable & rx_enable;

  astr_rx u_rx (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .tk        (rtk),
    .serial_in (serial_in),
    .done      (r_done),
    .data      (r_data),
    .stop_bad  (r_stop_bad),
    .noisy     (r_noisy),
    .brk       (r_brk),
    .busy      (r_busy)
  );

  // move character to buffer and flag full
  // break clears data and ninth bit, sets flags
  // overrun and noise may accompany a break
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_buffer    <= astr_pkg::DATA_RST;
      rx_ninth_bit   <= 1'b0;
      rx_buffer_full <= 1'b0;
      framing_error  <= 1'b0;
      break_flag     <= 1'b0;
      overrun_flag   <= 1'b0;
      noise_flag     <= 1'b0;
      parity_error   <= 1'b0;
      rx_in_progress <= 1'b0;
      rx_irq         <= 1'b0;
    end else begin
      rx_in_progress <= r_busy;
      rx_irq         <= rx_full_irq_en & (rx_buffer_full | r_done);
      if (r_done) begin
        if (rx_buffer_full && !data_read) begin
          overrun_flag <= 1'b1;
        end else begin
          data_buffer    <= r_brk ? 8'h00 : r_data[7:0];
          rx_ninth_bit   <= r_brk ? 1'b0 : r_data[8];
          rx_buffer_full <= 1'b1;
          framing_error  <= r_stop_bad;
          break_flag     <= break_flag | r_brk;
          noise_flag     <= r_noisy;
        end
      end else if (data_read) begin
        rx_buffer_full <= 1'b0;
        framing_error  <= 1'b0;
        break_flag     <= 1'b0;
        overrun_flag   <= 1'b0;
        noise_flag     <= 1'b0;
        parity_error   <= 1'b0;
      end
    end
  end

endmodule : astr_top
`default_nettype wire

// [dv/astr_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the serial block
module astr_chk #(
  parameter int BAUD_DIV = 1
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // controls
  input wire logic       module_enable,
  input wire logic       tx_enable,
  input wire logic       send_break,
  input wire logic       tx_polarity_invert,
  input wire logic       tx_empty_irq_en,
  input wire logic       rx_full_irq_en,
  input wire logic       status_read,
  input wire logic       data_write,
  // status
  input wire logic [7:0] data_buffer,
  input wire logic       rx_ninth_bit,
  input wire logic       tx_buffer_empty,
  input wire logic       tx_complete,
  input wire logic       rx_buffer_full,
  input wire logic       framing_error,
  input wire logic       break_flag,
  input wire logic       parity_error,
  input wire logic       tx_irq,
  input wire logic       rx_irq,
  // pins
  input wire logic       serial_out,
  input wire logic       serial_out_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // armed write: status read, then data write
  sequence armed_write_s;
    status_read ##1 (data_write && tx_enable && module_enable
                     && tx_buffer_empty && !tx_complete);
  endsequence
  // transmitter quiet for three cycles
  sequence quiet_s;
    (tx_complete && serial_out_oe && !send_break
     && $stable(tx_polarity_invert))[*3];
  endsequence

  buf_fill_a: assert property (armed_write_s |=> ##1 !tx_buffer_empty)
    else $error("armed write did not fill the buffer");
  empty_irq_a: assert property ($rose(tx_buffer_empty) && tx_empty_irq_en
    |-> ##[0:1] tx_irq) else $error("empty flag raised no tx request");
  full_irq_a: assert property ($rose(rx_buffer_full) && rx_full_irq_en
    |-> ##[0:1] rx_irq) else $error("full flag raised no rx request");
  break_regs_a: assert property ($rose(break_flag) |-> framing_error
    && rx_buffer_full && data_buffer == 8'h00 && !rx_ninth_bit)
    else $error("break left wrong receive state");
  frame_full_a: assert property ($rose(framing_error) |-> rx_buffer_full)
    else $error("framing error without full buffer");
  pin_release_a: assert property (!module_enable |-> ##[0:1] !serial_out_oe)
    else $error("pin still driven while disabled");
  idle_level_a: assert property (quiet_s |-> serial_out == !tx_polarity_invert)
    else $error("line not at idle level");
  break_busy_a: assert property (send_break && !tx_complete |=> !tx_complete)
    else $error("complete flag set during break");
  parity_off_a: assert property (!parity_error)
    else $error("parity error raised");
endmodule : astr_chk
`default_nettype wire

// [dv/astr_remote.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// remote serial device: frame decoder and frame sender
module astr_remote (
  // clock
  input  wire logic sys_clk,
  // wire from the block
  input  wire logic line,
  input  wire logic oe,
  input  wire logic inv,
  input  wire logic len9,
  // wire into the block
  output logic      serial_in
);
  logic [9:0] rxq[$];
  int         cyc       = 0;
  int         start_cyc = 0;

  // cycle count for timing checks
  always @(posedge sys_clk) cyc <= cyc + 1;

  // decoder: mid-bit samples, stop sample last
  // lsb first
  initial begin : dec
    logic [9:0] f;
    forever begin
      @(negedge sys_clk);
      if (oe === 1'b1 && (line ^ inv) === 1'b0) begin
        if (rxq.size() == 0) start_cyc = cyc;
        f = '0;
        repeat (8) @(negedge sys_clk);
        for (int i = 0; i < (len9 ? 10 : 9); i++) begin
          repeat (16) @(negedge sys_clk);
          f[i] = line ^ inv;
        end
        rxq.push_back(len9 ? f : {f[8], 1'b0, f[7:0]});
      end
    end
  end

  // line idles high between frames
  initial serial_in = 1'b1;

  // sender: idle gap, then frame bits lsb first
  // ones before start
  task automatic send(input logic [10:0] bits, input int n, input int gap);
    repeat (gap) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      serial_in = bits[i];
      repeat (16) @(negedge sys_clk);
    end
    serial_in = 1'b1;
  endtask : send
endmodule : astr_remote
`default_nettype wire

// [dv/astr_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// testbench top
module astr_top_tb_top;
  logic       sys_clk, reset, module_enable, tx_enable, rx_enable;
  logic       char_len_sel, send_break, tx_polarity_invert, tx_ninth_bit;
  logic       tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en;
  logic       status_read, data_write, data_read, serial_in;
  logic [7:0] data_wdata, data_buffer;
  logic       rx_ninth_bit, tx_buffer_empty, tx_complete, rx_buffer_full;
  logic       framing_error, break_flag, overrun_flag, noise_flag;
  logic       parity_error, rx_in_progress, tx_irq, rx_irq;
  logic       serial_out, serial_out_oe, tx_wire;
  logic [9:0] exp_q[$];
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         t_wr;

  astr_top #(.BAUD_DIV(1)) u_dut (.*);

  // released pin is pulled up
  assign tx_wire = serial_out_oe ? serial_out : 1'b1;

  astr_remote u_rem (.sys_clk(sys_clk), .line(tx_wire), .oe(serial_out_oe),
    .inv(tx_polarity_invert), .len9(char_len_sel), .serial_in(serial_in));

  // clock, 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // wait for buffer empty (0) or transmit complete (1)
  task automatic wait_flag(input bit sel);
    for (int i = 0; i < 4000; i++)
      if ((sel ? tx_complete : tx_buffer_empty) !== 1'b1) tick(1);
  endtask : wait_flag

  // host write: status read arms, data write follows
  // host sequence
  task automatic put(input logic [7:0] d);
    status_read = 1'b1;
    tick(1);
    status_read = 1'b0;
    data_write = 1'b1;
    data_wdata = d;
    tick(1);
    data_write = 1'b0;
    exp_q.push_back({1'b1, char_len_sel & tx_ninth_bit, d});
    tick(2);
  endtask : put

  // stop transmitter, set mode, restart it with empty queues
  task automatic tx_prep(input logic len, input logic inv, input logic ie);
    tx_enable = 1'b0;
    char_len_sel = len;
    tx_polarity_invert = inv;
    {tx_empty_irq_en, tx_done_irq_en} = {ie, ie};
    tick(300);
    u_rem.rxq.delete();
    exp_q.delete();
    tx_enable = 1'b1;
    t_wr = u_rem.cyc;
  endtask : tx_prep

  // four random characters, compared at the far side
  task automatic tx_run(input logic len, input logic inv, input logic ie);
    tx_prep(len, inv, ie);
    for (int k = 0; k < 4; k++) begin
      wait_flag(0);
      // queued idle, re-enabled well before the stop bit
      if (len && k == 2) begin
        tx_enable = 1'b0;
        tick(1);
        tx_enable = 1'b1;
      end
      tx_ninth_bit = 1'($urandom);
      put(8'($urandom));
    end
    // transmitter dropped inside the last character
    if (!len) begin
      wait_flag(0);
      tick(60);
      tx_enable = 1'b0;
    end
    wait_flag(1);
    chk(16'(u_rem.start_cyc - t_wr >= (len ? 158 : 142)), 16'h1);
    chk(16'(u_rem.rxq.size()), 16'h4);
    foreach (exp_q[j]) chk(16'(u_rem.rxq[j]), 16'(exp_q[j]));
    chk(16'(tx_irq), 16'(ie));
    chk(16'(serial_out), 16'(!inv));
  endtask : tx_run

  // main sequence
  initial begin : main
    logic [7:0] d;
    logic       b8;
    void'($urandom(54990));
    {module_enable, tx_enable, char_len_sel, send_break} = '0;
    {tx_polarity_invert, tx_ninth_bit, tx_empty_irq_en} = '0;
    {tx_done_irq_en, rx_full_irq_en, status_read, data_write} = '0;
    {data_read, data_wdata} = '0;
    rx_enable = 1'b1;
    reset = 1'b1;
    tick(12);
    reset = 1'b0;
    module_enable = 1'b1;
    tx_run(1'b0, 1'b0, 1'b0);
    tx_run(1'b1, 1'b1, 1'b1);
    // break characters, then release
    tx_prep(1'b0, 1'b0, 1'b0);
    send_break = 1'b1;
    tick(600);
    chk(16'(tx_complete), 16'h0);
    send_break = 1'b0;
    wait_flag(1);
    chk(16'(u_rem.rxq[0]), 16'h0);
    chk(16'(serial_out), 16'h1);
    // received characters in both lengths
    for (int k = 0; k < 8; k++) begin
      char_len_sel = k[0];
      rx_full_irq_en = k[1];
      d = 8'($urandom);
      b8 = 1'($urandom);
      u_rem.send(k[0] ? {1'b1, b8, d, 1'b0} : {2'b01, d, 1'b0},
                 k[0] ? 11 : 10, $urandom_range(0, 40));
      tick(4);
      chk(16'({overrun_flag, noise_flag, rx_buffer_full, framing_error,
               break_flag, rx_ninth_bit, data_buffer}),
          16'({5'h04, k[0] ? b8 : d[7], d}));
      chk(16'(rx_irq), 16'(k[1]));
      data_read = 1'b1;
      tick(1);
      data_read = 1'b0;
      tick(2);
      chk(16'(rx_buffer_full), 16'h0);
    end
    // received break characters in both lengths
    for (int k = 0; k < 2; k++) begin
      char_len_sel = k[0];
      u_rem.send(11'h000, k[0] ? 11 : 10, 20);
      tick(4);
      chk(16'({overrun_flag, noise_flag, rx_buffer_full, framing_error,
               break_flag, rx_ninth_bit, data_buffer}), 16'h0e00);
      data_read = 1'b1;
      tick(1);
      data_read = 1'b0;
      tick(40);
    end
    // module disable releases the pin
    module_enable = 1'b0;
    tick(3);
    chk(16'(serial_out_oe), 16'h0);
    test_done();
  end
endmodule : astr_top_tb_top

bind astr_top astr_chk #(.BAUD_DIV(BAUD_DIV)) u_chk (.*);
`default_nettype wire
